// ===== include/pom_pkg.sv
// Constants shared by the pulse output configuration block and its testbench.
// Assumes a single 200 MHz system clock and a plain register port.
//
// Notes on behaviour
// - Output one source in bits 2:0, five power codes, resets to total active.
// - Output one source codes 101, 110, 111 give no pulses at all.
// - Output two source in bits 5:3, same codes, resets to total reactive.
// - Output two source codes 101, 110, 111 suppress its pulses entirely.
// - Output three source in bits 8:6, same codes, resets to apparent.
// - Output three source codes 101, 110, 111 produce no pulses.
// - Each output sums only phases enabled by its compensation mode include field.
// - Codes for measurements a variant lacks have no effect on pulses.
// - Bit 9, reset 1, disables output one pin; converter keeps running.
// - Bit 10, reset 1, disables output two pin; converter keeps running.
// - Bit 11, reset 1, disables output three pin; converter keeps running.
// - Bit 12, reset 0, captures output one energy registers on each pulse.
// - Bit 13, reset 0, captures output two energy registers on each pulse.
// - Bit 14, reset 0, captures output three energy registers on each pulse.
// - Bit 15 reserved, resets 0, controls nothing.

`default_nettype none

package pom_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam int              ADDR_W      = 16;
	localparam int              DATA_W      = 16;
	localparam logic [15:0]     COMP_ADDR   = 16'hE60E;
	localparam logic [15:0]     MODE_ADDR   = 16'hE610;
	localparam logic [15:0]     STATUS_ADDR = 16'hE6F0;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int              NUM_OUT     = 3;
	localparam int              NUM_PHASE   = 3;
	localparam int              NUM_TYPE    = 5;
	localparam int              SRC_W       = 3;
	localparam int              SRC_LSB     = 0;
	localparam int              DIS_LSB     = 9;
	localparam int              LATCH_LSB   = 12;
	localparam int              MODE_W      = 15;
	localparam int              COMP_W      = 9;
	localparam int              STAT_ACT    = 0;
	localparam int              STAT_EN     = 3;
	localparam int              STAT_W      = 6;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [14:0]     MODE_RESET  = 15'h0E88;
	localparam logic [8:0]      COMP_RESET  = 9'h1FF;

	// ---------------------------------------------------------------
	// Source codes
	// ---------------------------------------------------------------
	localparam logic [2:0]      SRC_TOT_ACT   = 3'h0;
	localparam logic [2:0]      SRC_TOT_REACT = 3'h1;
	localparam logic [2:0]      SRC_APPARENT  = 3'h2;
	localparam logic [2:0]      SRC_FUND_ACT  = 3'h3;
	localparam logic [2:0]      SRC_FUND_REACT = 3'h4;
	localparam logic [2:0]      SRC_LAST      = 3'h4;

endpackage : pom_pkg

`default_nettype wire

// ===== src/pom_dfc.sv
// Digital-to-frequency converter for one pulse output.
// Assumes sample strobes and power sums come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pom_dfc #(
	parameter int                SUM_W        = 20,
	parameter int                ACC_W        = 32,
	parameter logic [ACC_W-1:0]  THRESHOLD    = 32'h0001_0000,
	parameter int                PULSE_CYCLES = 16
) (
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	input  wire logic                    sample,
	input  wire logic signed [SUM_W-1:0] power,
	output logic                         fire,
	output logic                         active
);

	localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

	initial
	begin
		if (ACC_W <= SUM_W || THRESHOLD == '0 || PULSE_CYCLES < 1)
			$error("pom_dfc: unsupported parameters");
	end

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [CNT_W-1:0] cnt;
		logic             fire;
		logic             active;
	} pom_dfc_s;

	pom_dfc_s st;
	pom_dfc_s next_st;

	logic [SUM_W-1:0] mag;
	logic [ACC_W-1:0] acc_sum;

	assign mag = power[SUM_W-1] ? SUM_W'(-power) : SUM_W'(power);

	// ---------------------------------------------------------------
	// Accumulate magnitude, fire on threshold, stretch the pulse
	// ---------------------------------------------------------------
	always_comb
	begin
		next_st      = st;
		next_st.fire = 1'b0;
		acc_sum      = st.acc + ACC_W'(mag);
		if (st.active)
		begin
			if (st.cnt == '0)
				next_st.active = 1'b0;
			else
				next_st.cnt = st.cnt - CNT_W'(1);
		end
		if (sample)
		begin
			if (acc_sum >= THRESHOLD)
			begin
				next_st.acc    = acc_sum - THRESHOLD;
				next_st.fire   = 1'b1;
				next_st.active = 1'b1;
				next_st.cnt    = CNT_W'(PULSE_CYCLES - 1);
			end
			else
				next_st.acc = acc_sum;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign fire   = st.fire;
	assign active = st.active;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	fire_starts_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st.fire |-> st.active)
		else $error("converter pulse did not start with fire");

endmodule : pom_dfc

`default_nettype wire

// ===== src/pom_pulse_config.sv
// Pulse output configuration bank: source select, pin disable and
// energy capture enable for three calibration pulse outputs.
// Assumes per-phase power words and a sample strobe from the metering
// datapath on mclk, and a register master on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pom_pulse_config #(
	parameter int                POWER_W         = 16,
	parameter int                ACC_W           = 32,
	parameter logic [31:0]       THRESHOLD       = 32'h0001_0000,
	parameter int                PULSE_CYCLES    = 16,
	parameter bit                HAS_REACTIVE    = 1'b1,
	parameter bit                HAS_FUNDAMENTAL = 1'b1
) (
	input  wire logic                                       mclk,
	input  wire logic                                       reset_n,
	input  wire logic [pom_pkg::ADDR_W-1:0]                 reg_addr,
	input  wire logic [pom_pkg::DATA_W-1:0]                 reg_wdata,
	input  wire logic                                       reg_write,
	input  wire logic                                       reg_read,
	output logic      [pom_pkg::DATA_W-1:0]                 reg_rdata,
	input  wire logic                                       sample_valid,
	input  wire logic [pom_pkg::NUM_PHASE-1:0][pom_pkg::NUM_TYPE-1:0][POWER_W-1:0] phase_power,
	output logic                                            pulse_output_one_n,
	output logic                                            pulse_output_two_n,
	output logic                                            pulse_output_three_n,
	output logic                                            pulse_one_energy_capture,
	output logic                                            pulse_two_energy_capture,
	output logic                                            pulse_three_energy_capture
);

	localparam int SUM_W = POWER_W + 2;
	localparam int NO    = pom_pkg::NUM_OUT;

	initial
	begin
		if (POWER_W < 2 || ACC_W <= SUM_W || PULSE_CYCLES < 1 || THRESHOLD == '0)
			$error("pom_pulse_config: unsupported parameters");
	end

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [pom_pkg::MODE_W-1:0] mode;
		logic [pom_pkg::COMP_W-1:0] comp;
		logic [pom_pkg::DATA_W-1:0] rdata;
		logic [NO-1:0]              pin_n;
		logic [NO-1:0]              cap;
	} pom_top_s;

	localparam pom_top_s ST_RESET = '{
		mode:  pom_pkg::MODE_RESET,
		comp:  pom_pkg::COMP_RESET,
		rdata: '0,
		pin_n: '1,
		cap:   '0
	};

	pom_top_s st;
	pom_top_s next_st;

	logic [NO-1:0]           code_ok;
	logic [NO-1:0]           out_en;
	logic [NO-1:0]           cap_en;
	logic [NO-1:0]           dfc_fire;
	logic [NO-1:0]           dfc_active;

	// ---------------------------------------------------------------
	// Per output source selection and phase summation
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NO; i++)
	begin : g_out
		logic [pom_pkg::SRC_W-1:0] src;
		logic                      supported;
		logic signed [SUM_W-1:0]   sum;

		assign src        = st.mode[pom_pkg::SRC_LSB + pom_pkg::SRC_W*i +: pom_pkg::SRC_W];
		assign code_ok[i] = (src <= pom_pkg::SRC_LAST);
		assign out_en[i]  = !st.mode[pom_pkg::DIS_LSB + i] && code_ok[i];
		assign cap_en[i]  = st.mode[pom_pkg::LATCH_LSB + i];

		// Missing measurements contribute nothing
		assign supported =
			!((src == pom_pkg::SRC_TOT_REACT) && !HAS_REACTIVE) &&
			!((src == pom_pkg::SRC_FUND_ACT || src == pom_pkg::SRC_FUND_REACT)
				&& !HAS_FUNDAMENTAL);

		always_comb
		begin
			sum = '0;
			if (code_ok[i] && supported)
			begin
				for (int p = 0; p < pom_pkg::NUM_PHASE; p++)
				begin
					if (st.comp[i*pom_pkg::NUM_PHASE + p])
						sum = sum + SUM_W'($signed(phase_power[p][src]));
				end
			end
		end

		// Converter runs whatever the pin disable says
		pom_dfc #(
			.SUM_W        (SUM_W),
			.ACC_W        (ACC_W),
			.THRESHOLD    (ACC_W'(THRESHOLD)),
			.PULSE_CYCLES (PULSE_CYCLES)
		) u_dfc (
			.mclk    (mclk),
			.reset_n (reset_n),
			.sample  (sample_valid),
			.power   (sum),
			.fire    (dfc_fire[i]),
			.active  (dfc_active[i])
		);

		// -----------------------------------------------------------
		// Per output checks
		// -----------------------------------------------------------
		reserved_code_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
			!code_ok[i] |=> st.pin_n[i])
			else $error("pulse pin active under reserved source code");

		reserved_no_capture_a: assert property (@(posedge mclk) disable iff (!reset_n)
			!code_ok[i] |=> !st.cap[i])
			else $error("capture strobe under reserved source code");

		disabled_pin_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
			st.mode[pom_pkg::DIS_LSB + i] |=> st.pin_n[i])
			else $error("disabled pulse pin left idle level");

		enabled_pin_drive_a: assert property (@(posedge mclk) disable iff (!reset_n)
			(dfc_active[i] && out_en[i]) |=> !st.pin_n[i])
			else $error("enabled pulse pin did not follow converter");

		capture_on_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
			(dfc_fire[i] && cap_en[i] && code_ok[i]) |=> st.cap[i])
			else $error("energy capture missed a pulse");

		capture_only_enabled_a: assert property (@(posedge mclk) disable iff (!reset_n)
			(!cap_en[i] || !dfc_fire[i]) |=> !st.cap[i])
			else $error("energy capture without enable and pulse");

		phase_mask_a: assert property (@(posedge mclk) disable iff (!reset_n)
			(st.comp[i*pom_pkg::NUM_PHASE +: pom_pkg::NUM_PHASE] == '0) |-> (sum == '0))
			else $error("power sum nonzero with no phase included");

		variant_missing_a: assert property (@(posedge mclk) disable iff (!reset_n)
			!supported |-> (sum == '0))
			else $error("unsupported source fed the converter");

		disabled_fire_c: cover property (@(posedge mclk) disable iff (!reset_n)
			st.mode[pom_pkg::DIS_LSB + i] && dfc_fire[i]);
	end

	// ---------------------------------------------------------------
	// Register port and pin update
	// ---------------------------------------------------------------
	always_comb
	begin
		next_st       = st;
		next_st.rdata = '0;
		if (reg_write)
		begin
			unique case (reg_addr)
				pom_pkg::MODE_ADDR:
					next_st.mode = reg_wdata[pom_pkg::MODE_W-1:0];
				pom_pkg::COMP_ADDR:
					next_st.comp = reg_wdata[pom_pkg::COMP_W-1:0];
				default:
					next_st.mode = st.mode;
			endcase
		end
		if (reg_read)
		begin
			unique case (reg_addr)
				pom_pkg::MODE_ADDR:
					next_st.rdata = {1'b0, st.mode};
				pom_pkg::COMP_ADDR:
					next_st.rdata = {{(pom_pkg::DATA_W-pom_pkg::COMP_W){1'b0}}, st.comp};
				pom_pkg::STATUS_ADDR:
					next_st.rdata = {{(pom_pkg::DATA_W-pom_pkg::STAT_W){1'b0}},
						out_en, dfc_active};
				default:
					next_st.rdata = '0;
			endcase
		end
		next_st.pin_n = ~(dfc_active & out_en);
		next_st.cap   = dfc_fire & cap_en & code_ok;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			st <= ST_RESET;
		else
			st <= next_st;
	end

	assign reg_rdata                  = st.rdata;
	assign pulse_output_one_n         = st.pin_n[0];
	assign pulse_output_two_n         = st.pin_n[1];
	assign pulse_output_three_n       = st.pin_n[2];
	assign pulse_one_energy_capture   = st.cap[0];
	assign pulse_two_energy_capture   = st.cap[1];
	assign pulse_three_energy_capture = st.cap[2];

	// ---------------------------------------------------------------
	// Reset value and register checks
	// ---------------------------------------------------------------
	src_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(reset_n) |-> (st.mode[8:0] == 9'h088))
		else $error("source fields not at reset codes");

	dis_latch_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(reset_n) |-> (st.mode[14:9] == 6'h07))
		else $error("disable or capture bits not at reset value");

	reserved_bit_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_read && reg_addr == pom_pkg::MODE_ADDR) |=> !reg_rdata[15])
		else $error("reserved mode bit read back nonzero");

	mode_readback_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_write && reg_addr == pom_pkg::MODE_ADDR)
		##1 (reg_read && reg_addr == pom_pkg::MODE_ADDR)
		|=> (reg_rdata == ($past(reg_wdata, 2) & 16'h7FFF)))
		else $error("mode register read back wrong value");

	write_disable_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
		(reg_write && reg_addr == pom_pkg::MODE_ADDR && reg_wdata[9])
		|=> ##1 pulse_output_one_n)
		else $error("output one pin active after disable write");

	pin_pulse_c: cover property (@(posedge mclk) disable iff (!reset_n)
		$fell(pulse_output_one_n));

	capture_c: cover property (@(posedge mclk) disable iff (!reset_n)
		pulse_two_energy_capture);

	reserved_code_c: cover property (@(posedge mclk) disable iff (!reset_n)
		!code_ok[2] && dfc_active[2]);

	status_read_c: cover property (@(posedge mclk) disable iff (!reset_n)
		reg_read && reg_addr == pom_pkg::STATUS_ADDR);

endmodule : pom_pulse_config

`default_nettype wire

// ===== tb/pom_tb.sv
// Self-checking bench for the pulse output configuration bank.
// Assumes pom_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module testbench;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int          PC = 2;
	logic                   mclk;
	logic                   reset_n;
	logic [15:0]            reg_addr;
	logic [15:0]            reg_wdata;
	logic                   reg_write;
	logic                   reg_read;
	logic [15:0]            reg_rdata;
	logic                   sample_valid;
	logic [2:0][4:0][15:0]  phase_power;
	logic [2:0]             pin_n;
	logic [2:0]             cap;
	logic [2:0]             pin_lite_n;
	logic [2:0]             cap_lite;
	logic                   rd_seen;
	logic [15:0]            rd_exp [$];
	logic [31:0]            seed;
	int                     n_fail;
	int                     checks_done;
	int                     cycles;

	pom_pulse_config #(
		.POWER_W      (16),
		.THRESHOLD    (32'h0000_0010),
		.PULSE_CYCLES (PC)
	) uut (
		.mclk                       (mclk),
		.reset_n                    (reset_n),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_write                  (reg_write),
		.reg_read                   (reg_read),
		.reg_rdata                  (reg_rdata),
		.sample_valid               (sample_valid),
		.phase_power                (phase_power),
		.pulse_output_one_n         (pin_n[0]),
		.pulse_output_two_n         (pin_n[1]),
		.pulse_output_three_n       (pin_n[2]),
		.pulse_one_energy_capture   (cap[0]),
		.pulse_two_energy_capture   (cap[1]),
		.pulse_three_energy_capture (cap[2])
	);

	// Variant without reactive and fundamental measurement
	pom_pulse_config #(
		.POWER_W         (16),
		.THRESHOLD       (32'h0000_0010),
		.PULSE_CYCLES    (PC),
		.HAS_REACTIVE    (1'b0),
		.HAS_FUNDAMENTAL (1'b0)
	) uut_lite (
		.mclk                       (mclk),
		.reset_n                    (reset_n),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_write                  (reg_write),
		.reg_read                   (reg_read),
		.reg_rdata                  (),
		.sample_valid               (sample_valid),
		.phase_power                (phase_power),
		.pulse_output_one_n         (pin_lite_n[0]),
		.pulse_output_two_n         (pin_lite_n[1]),
		.pulse_output_three_n       (pin_lite_n[2]),
		.pulse_one_energy_capture   (cap_lite[0]),
		.pulse_two_energy_capture   (cap_lite[1]),
		.pulse_three_energy_capture (cap_lite[2])
	);

	// ---------------------------------------------------------------
	// Clock and hang guard
	// ---------------------------------------------------------------
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 10000)
		begin
			n_fail = n_fail + 1;
			report_and_stop();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		logic [31:0] r;
		r = s;
		for (int i = 0; i < 16; i++)
			r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
		return r;
	endfunction : lfsr

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
	endtask : do_reset

	// Bus tasks start right after a rising edge and end on the next one
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		reg_read  <= 1'b0;
		@(posedge mclk);
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		reg_addr  <= a;
		reg_write <= 1'b0;
		reg_read  <= 1'b1;
		rd_exp.push_back(exp);
		@(posedge mclk);
	endtask : rd

	task automatic idle();
		reg_write <= 1'b0;
		reg_read  <= 1'b0;
		@(posedge mclk);
	endtask : idle

	// Read data stand the cycle after the read, zero in every other
	always @(posedge mclk)
	begin
		if (rd_seen)
			check(reg_rdata, rd_exp.pop_front());
		else
			check(reg_rdata, 16'h0000);
		rd_seen <= reg_read;
	end

	// ---------------------------------------------------------------
	// One output, one source code, random other fields and one sample
	// ---------------------------------------------------------------
	task automatic run_case(input int o, input logic [2:0] code);
		logic [15:0] m;
		logic [15:0] st_exp;
		logic [8:0]  inc;
		int          p;
		int          t;
		int          lows;
		int          caps;
		int          lows_lite;
		int          caps_lite;
		int          first;
		int          capat;
		logic        fire;
		logic        fire_lite;
		seed = lfsr(seed);
		m = seed[15:0];
		m[3*o +: 3] = code;
		inc = seed[24:16];
		p = int'(seed[26:25]) % 3;
		t = (seed[27] && code <= 3'h4) ? int'(code) : int'(seed[30:28]) % 5;
		fire = (code <= 3'h4) && (t == int'(code)) && inc[3*o+p];
		fire_lite = fire && (code == 3'h0 || code == 3'h2);
		st_exp = 16'h0000;
		for (int j = 0; j < 3; j++)
			st_exp[3 + j] = !m[9 + j] && (m[3*j +: 3] <= 3'h4);
		do_reset();
		wr(pom_pkg::COMP_ADDR, {7'h00, inc});
		wr(pom_pkg::MODE_ADDR, m);
		rd(pom_pkg::MODE_ADDR, m & 16'h7FFF);
		rd(pom_pkg::COMP_ADDR, {7'h00, inc});
		rd(pom_pkg::STATUS_ADDR, st_exp);
		idle();
		sample_valid <= 1'b1;
		phase_power[p][t] <= seed[31] ? 16'hFFF0 : 16'h0010;
		@(posedge mclk);
		sample_valid <= 1'b0;
		phase_power  <= '0;
		lows      = 0;
		caps      = 0;
		lows_lite = 0;
		caps_lite = 0;
		first     = -1;
		capat     = -2;
		for (int i = 0; i < 10; i++)
		begin
			@(negedge mclk);
			if (pin_lite_n[o] !== 1'b1)
				lows_lite++;
			if (cap_lite[o] !== 1'b0)
				caps_lite++;
			if (pin_n[o] !== 1'b1)
			begin
				lows++;
				if (first < 0)
					first = i;
			end
			if (cap[o] !== 1'b0)
			begin
				caps++;
				capat = i;
			end
		end
		check(16'(lows), (fire && !m[9+o]) ? 16'(PC) : 16'h0000);
		check(16'(caps), {15'h0000, fire && m[12+o]});
		if (fire && !m[9+o] && m[12+o])
			check(16'(capat), 16'(first));
		check(16'(lows_lite), (fire_lite && !m[9+o]) ? 16'(PC) : 16'h0000);
		check(16'(caps_lite), {15'h0000, fire_lite && m[12+o]});
		$display("case output %0d code %0d done", o + 1, code);
	endtask : run_case

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		reset_n      = 1'b0;
		reg_addr     = 16'h0000;
		reg_wdata    = 16'h0000;
		reg_write    = 1'b0;
		reg_read     = 1'b0;
		sample_valid = 1'b0;
		phase_power  = '0;
		seed         = 32'hACDF;
		rd_seen      = 1'b0;
		n_fail       = 0;
		checks_done  = 0;
		cycles       = 0;
		do_reset();
		wr(16'hE612, 16'hFFFF);
		rd(pom_pkg::MODE_ADDR, 16'h0E88);
		rd(pom_pkg::COMP_ADDR, 16'h01FF);
		rd(pom_pkg::STATUS_ADDR, 16'h0000);
		rd(16'hE612, 16'h0000);
		wr(pom_pkg::MODE_ADDR, 16'hFFFF);
		rd(pom_pkg::MODE_ADDR, 16'h7FFF);
		idle();
		$display("test reset values and register access done");
		for (int rep = 0; rep < 4; rep++)
			for (int o = 0; o < 3; o++)
				for (int c = 0; c < 8; c++)
					run_case(o, 3'(c));
		$display("test source, disable and capture sweep done");
		report_and_stop();
	end

endmodule : testbench

`default_nettype wire
